// File: logic/occ_pkg.sv
// Constants, types and command codes of the output channel control block
`default_nettype none
package occ_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CH = 10;
  localparam int FB_BITS = 4;
  localparam int FB_CH_BASE = 6;
  localparam int FRAME_W = 16;
  localparam int REG_W = 12;
  localparam int SEL_W = 2;
  localparam int SEL_LO_CH = 6;
  localparam int SEL_HI_CH = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

  // ****************************************************************
  // Serial frame carrier
  // ****************************************************************
  typedef struct packed {
    logic [3:0] cmd;
    logic [REG_W-1:0] data;
  } occ_frame_t;

  // Command codes in the frame's upper nibble
  localparam logic [3:0] CMD_PIN_SET = 4'h1;
  localparam logic [3:0] CMD_RD = 4'h4;
  localparam logic [3:0] CMD_DIAG_CLR = 4'h5;
  localparam logic [3:0] CMD_WR_ON = 4'h8;
  localparam logic [3:0] CMD_WR_SEL_LO = 4'h9;
  localparam logic [3:0] CMD_WR_SEL_HI = 4'ha;
  localparam logic [3:0] CMD_WR_PAIR = 4'hb;

  // Read selector in the low data bits of a read command
  localparam logic [1:0] RD_ON = 2'h0;
  localparam logic [1:0] RD_SEL_LO = 2'h1;
  localparam logic [1:0] RD_SEL_HI = 2'h2;
  localparam logic [1:0] RD_PAIR = 2'h3;

  // ****************************************************************
  // Reset values, writable masks and fixed levels
  // ****************************************************************
  localparam logic [REG_W-1:0] RST_ON = 12'hc00;
  localparam logic [REG_W-1:0] RST_SEL_LO = 12'haaa;
  localparam logic [REG_W-1:0] RST_SEL_HI = 12'h0aa;
  localparam logic [REG_W-1:0] RST_PAIR = 12'h000;
  localparam logic [REG_W-1:0] WMASK_ON = 12'h3ff;
  localparam logic [REG_W-1:0] WMASK_SEL_LO = 12'hfff;
  localparam logic [REG_W-1:0] WMASK_SEL_HI = 12'h0ff;
  localparam logic [REG_W-1:0] WMASK_PAIR = 12'h0f7;
  localparam logic [7:0] RST_PIN_SET = 8'h00;
  localparam logic [3:0] RSP_PAD = 4'h0;

  // Pin-set field layout: low nibble mode, high nibble values
  localparam int OPS_SEL_LSB = 0;
  localparam int OPS_VAL_LSB = 4;

  // Source select codes; upper bit low means register control
  localparam int SEL_HI_BIT = 1;
  localparam logic [SEL_W-1:0] SEL_IN_PIN = 2'h2;
  localparam logic [SEL_W-1:0] SEL_AND = 2'h3;

  // Channels that have a pairing link to their lower neighbour
  localparam logic [NUM_CH-1:0] LINK_HAS = 10'h3ae;

  // Pairing bit that links channel k (from 0) with channel k-1
  function automatic int link_idx(input int k);
    case (k)
      1: link_idx = 0;
      2: link_idx = 1;
      3: link_idx = 2;
      5: link_idx = 4;
      7: link_idx = 5;
      8: link_idx = 6;
      9: link_idx = 7;
      default: link_idx = 0;
    endcase
  endfunction : link_idx

  // ****************************************************************
  // Frame sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_DONE = 3'h4
  } occ_state_t;
endpackage : occ_pkg
`default_nettype wire

// File: logic/occ_src_mux.sv
// Per-channel choice between register bit, input pin or their AND
`timescale 1ns/1ps
`default_nettype none
module occ_src_mux
  import occ_pkg::*;
(
  input wire logic [SEL_W-1:0] sel, // Source select field
  input wire logic on_bit, // Channel on/off register bit
  input wire logic in_pin, // Channel input pin
  output logic drive // Resulting channel command
);
  always_comb begin
    if (!sel[SEL_HI_BIT]) begin
      drive = on_bit;
    end else if (sel == SEL_IN_PIN) begin
      drive = in_pin;
    end else begin
      drive = on_bit & in_pin;
    end
  end
endmodule : occ_src_mux
`default_nettype wire

// File: logic/occ_fb_bit.sv
// One bit of the pin feedback field
`timescale 1ns/1ps
`default_nettype none
module occ_fb_bit (
  input wire logic par_sel, // Previous frame picked parallel mode
  input wire logic sent_val, // Value sent in the previous frame
  input wire logic in_pin, // Live input pin, caught at frame start
  output logic fb // Feedback bit
);
  // Each bit decides on its own, so one frame can mix sources
  assign fb = par_sel ? in_pin : sent_val;
endmodule : occ_fb_bit
`default_nettype wire

// File: logic/occ_ctrl.sv
// Output channel control: serial frames, registers, pairing, feedback
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Response upper byte carries the eight-bit pin feedback field.
// - Serial-mode channels 7-10 echo the value sent last frame.
// - Parallel-mode channels 7-10 return the pin level at chip select fall.
// - Feedback source is chosen per channel; frames may mix both.
// - Ten on/off bits in the twelve-bit register, one per channel, one means on.
// - On/off bit drives the channel only when select upper bit is zero.
// - Twelve-bit on/off register resets to c00, top two bits fixed one.
// - Select code 10 makes the channel follow its input pin.
// - Select code 11 turns channel on only if bit and pin are one.
// - Low select bank: six fields, channel 1 lowest, resets to aaa.
// - High select bank: four fields in low byte, upper zero, resets 0aa.
// - Pairing bits 0-2 and 4-7 as listed; bit 3 and 11-8 zero.
// - A set pairing bit drives both outputs from the lower channel.
// - Pairing works only within groups 1-4, 5-6 and 7-10.
// - Pairing register resets to 000, all channels independent.
// - Diagnosis sets only the faulty channel's bit, even when paired.
// - Every frame shifted in returns a response frame in the same transfer.
module occ_ctrl
  import occ_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic spi_cs_n, // Serial chip select, active low
  input wire logic spi_sclk, // Serial clock, idle low
  input wire logic spi_si, // Serial data in
  output logic spi_so, // Serial data out
  output logic spi_so_oe_n, // Serial data out enable, active low
  input wire logic [NUM_CH-1:0] channel_input_pin, // Parallel inputs
  input wire logic [NUM_CH-1:0] channel_fault, // Per-channel fault
  output logic [NUM_CH-1:0] channel_drive, // Power stage commands
  output logic [NUM_CH-1:0] diag_flags // Sticky diagnosis bits
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  occ_state_t state_r;
  occ_state_t state_nxt;
  logic cs_q_r;
  logic sclk_q_r;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [FRAME_W-1:0] rx_sh_r;
  logic [FRAME_W-1:0] tx_sh_r;
  logic [CNT_W-1:0] bit_cnt_r;
  occ_frame_t frame;
  logic frame_ok;
  logic [REG_W-1:0] on_off_r;
  logic [REG_W-1:0] sel_lo_r;
  logic [REG_W-1:0] sel_hi_r;
  logic [REG_W-1:0] pair_r;
  logic [7:0] pin_set_r;
  logic rd_pend_r;
  logic [1:0] rd_sel_r;
  logic [REG_W-1:0] rd_val;
  logic [FB_BITS-1:0] fb_now;
  logic [7:0] pin_feedback;
  logic [FRAME_W-1:0] rsp_word;
  logic [SEL_W*NUM_CH-1:0] sel_vec;
  logic [NUM_CH-1:0] own_drive;
  logic [NUM_CH-1:0] chained;
  logic [NUM_CH-1:0] drive_r;
  logic [NUM_CH-1:0] diag_r;
  logic so_oe_n_r;
  logic wr_on;
  logic wr_sel_lo;
  logic wr_sel_hi;
  logic wr_pair;
  logic wr_pin_set;
  logic diag_clr;
  logic rd_cmd;

  // ****************************************************************
  // Edge detection on the serial pins
  // ****************************************************************
  // Pins count as synchronous, so one stage of history is enough
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
    end else begin
      cs_q_r <= spi_cs_n;
      sclk_q_r <= spi_sclk;
    end
  end

  assign cs_fall = cs_q_r & ~spi_cs_n;
  assign cs_rise = ~cs_q_r & spi_cs_n;
  assign sclk_rise = ~sclk_q_r & spi_sclk & ~spi_cs_n;
  assign sclk_fall = sclk_q_r & ~spi_sclk & ~spi_cs_n;

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = cs_fall ? ST_SHIFT : ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Receive shifter and bit counter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_r <= '0;
      bit_cnt_r <= '0;
    end else if (cs_fall) begin
      bit_cnt_r <= '0;
    end else if (state_r == ST_SHIFT && sclk_rise) begin
      rx_sh_r <= {rx_sh_r[FRAME_W-2:0], spi_si};
      if (bit_cnt_r != CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  // Frames of any other length are dropped, so a broken transfer
  // never lands a half-shifted word in a register
  assign frame = occ_frame_t'(rx_sh_r);
  assign frame_ok = (state_r == ST_DONE) && (bit_cnt_r == FRAME_BITS);

  // ****************************************************************
  // Command strobes
  // ****************************************************************
  // One cycle wide on a committed frame; an unknown code raises none,
  // so it leaves every register but rd_pend_r and rd_sel_r as it was
  assign wr_on = frame_ok && (frame.cmd == CMD_WR_ON);
  assign wr_sel_lo = frame_ok && (frame.cmd == CMD_WR_SEL_LO);
  assign wr_sel_hi = frame_ok && (frame.cmd == CMD_WR_SEL_HI);
  assign wr_pair = frame_ok && (frame.cmd == CMD_WR_PAIR);
  assign wr_pin_set = frame_ok && (frame.cmd == CMD_PIN_SET);
  assign diag_clr = frame_ok && (frame.cmd == CMD_DIAG_CLR);
  assign rd_cmd = frame_ok && (frame.cmd == CMD_RD);

  // ****************************************************************
  // Response frame
  // ****************************************************************
  // Register readback; fixed bits come out at their fixed level
  always_comb begin
    unique case (rd_sel_r)
      RD_ON: rd_val = on_off_r;
      RD_SEL_LO: rd_val = sel_lo_r;
      RD_SEL_HI: rd_val = sel_hi_r;
      RD_PAIR: rd_val = pair_r;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < FB_BITS; g++) begin : g_fb
      occ_fb_bit u_fb (
        .par_sel(pin_set_r[OPS_SEL_LSB+g]),
        .sent_val(pin_set_r[OPS_VAL_LSB+g]),
        .in_pin(channel_input_pin[FB_CH_BASE+g]),
        .fb(fb_now[g])
      );
    end
  endgenerate

  // Value bits of serial-mode channels stay in the upper nibble
  assign pin_feedback = {fb_now, pin_set_r[OPS_VAL_LSB-1:OPS_SEL_LSB]};

  always_comb begin
    if (rd_pend_r) begin
      rsp_word = {RSP_PAD, rd_val};
    end else begin
      rsp_word = {pin_feedback, diag_r[7:0]};
    end
  end

  // Response loads at chip select fall, so pins are caught there
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_r <= '0;
    end else if (cs_fall) begin
      tx_sh_r <= rsp_word;
    end else if (state_r == ST_SHIFT && sclk_fall) begin
      tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
    end
  end

  // Enable follows chip select one clock late, like every other output
  always_ff @(posedge clk) begin
    if (rst) begin
      so_oe_n_r <= 1'b1;
    end else begin
      so_oe_n_r <= spi_cs_n;
    end
  end

  // ****************************************************************
  // Command decode: registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      on_off_r <= RST_ON;
    end else if (wr_on) begin
      on_off_r <= (frame.data & WMASK_ON) | RST_ON;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_lo_r <= RST_SEL_LO;
    end else if (wr_sel_lo) begin
      sel_lo_r <= frame.data & WMASK_SEL_LO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_hi_r <= RST_SEL_HI;
    end else if (wr_sel_hi) begin
      sel_hi_r <= frame.data & WMASK_SEL_HI;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pair_r <= RST_PAIR;
    end else if (wr_pair) begin
      pair_r <= frame.data & WMASK_PAIR;
    end
  end

  // Pin-set bits are kept for the next frame's feedback
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_set_r <= RST_PIN_SET;
    end else if (wr_pin_set) begin
      pin_set_r <= frame.data[7:0];
    end
  end

  // A read answers in the next frame, then the feedback word returns
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_sel_r <= RD_ON;
    end else if (frame_ok) begin
      rd_pend_r <= rd_cmd;
      rd_sel_r <= frame.data[1:0];
    end
  end

  // ****************************************************************
  // Channel drive with pairing
  // ****************************************************************
  assign sel_vec = {sel_hi_r[SEL_W*SEL_HI_CH-1:0], sel_lo_r};

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      occ_src_mux u_mux (
        .sel(sel_vec[SEL_W*g +: SEL_W]),
        .on_bit(on_off_r[g]),
        .in_pin(channel_input_pin[g]),
        .drive(own_drive[g])
      );
    end
  endgenerate

  // Chained links let 1-2 and 2-3 both set drive three from channel 1;
  // links never cross a group edge, as LINK_HAS has no bit there
  always_comb begin
    chained[0] = own_drive[0];
    for (int k = 1; k < NUM_CH; k++) begin
      if (LINK_HAS[k] && pair_r[link_idx(k)]) begin
        chained[k] = chained[k-1];
      end else begin
        chained[k] = own_drive[k];
      end
    end
  end

  // Registered so a settling mux chain never reaches a power stage
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_r <= '0;
    end else begin
      drive_r <= chained;
    end
  end

  // ****************************************************************
  // Diagnosis flags
  // ****************************************************************
  // Each flag follows its own channel only; the host merges pairs.
  // A fault in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      diag_r <= '0;
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (channel_fault[k]) begin
          diag_r[k] <= 1'b1;
        end else if (diag_clr) begin
          diag_r[k] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign spi_so = tx_sh_r[FRAME_W-1];
  assign spi_so_oe_n = so_oe_n_r;
  assign channel_drive = drive_r;
  assign diag_flags = diag_r;
endmodule : occ_ctrl
`default_nettype wire

// File: verification/occ_ctrl_checker.sv
// Port-level assertions for the output channel control block
`timescale 1ns/1ps
`default_nettype none
module occ_ctrl_checker
  import occ_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic spi_cs_n, // Chip select
  input wire logic spi_sclk, // Serial clock
  input wire logic spi_so, // Serial data out
  input wire logic spi_so_oe_n, // Data out enable
  input wire logic [NUM_CH-1:0] channel_input_pin, // Parallel inputs
  input wire logic [NUM_CH-1:0] channel_fault, // Faults
  input wire logic [NUM_CH-1:0] channel_drive, // Channel commands
  input wire logic [NUM_CH-1:0] diag_flags // Diagnosis bits
);
  logic [NUM_CH-1:0] pin_q;
  logic [2:0] quiet_cnt;
  logic no_frame;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // Helpers
  // ********
  always_ff @(posedge clk) pin_q <= channel_input_pin;
  // Quiet: no frame and no pin change, so nothing may move the drive
  always_ff @(posedge clk) begin
    if (rst || !spi_cs_n || channel_input_pin != pin_q) quiet_cnt <= 3'h0;
    else if (quiet_cnt != 3'h7) quiet_cnt <= quiet_cnt + 3'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) no_frame <= 1'b1;
    else if (!spi_cs_n) no_frame <= 1'b0;
  end
  // ********
  // Checks
  // ********
  a_oe_follows_cs: assert property (
    !$past(rst) |-> spi_so_oe_n == $past(spi_cs_n))
    else $error("data out enable does not follow chip select");
  a_so_holds_high: assert property (
    spi_sclk && $past(spi_sclk) && !spi_cs_n |-> $stable(spi_so))
    else $error("data out moved while serial clock high");
  a_reset_outputs: assert property (
    $past(rst) |-> channel_drive == '0 && diag_flags == '0 && spi_so_oe_n)
    else $error("outputs not at reset level");
  a_pin_mode_reset: assert property (
    no_frame && !$past(rst) |-> channel_drive == $past(channel_input_pin))
    else $error("drive does not follow pins after reset");
  a_drive_quiet: assert property (
    quiet_cnt >= 3'h6 |-> $stable(channel_drive))
    else $error("drive moved without cause");
  a_diag_sets: assert property (
    |channel_fault |=>
      (diag_flags & $past(channel_fault)) == $past(channel_fault))
    else $error("fault not flagged");
  a_diag_only_faulty: assert property (
    (diag_flags & ~$past(diag_flags)) != '0 |->
      (diag_flags & ~$past(diag_flags) & ~$past(channel_fault)) == '0)
    else $error("flag set without fault");
  a_diag_sticky: assert property (
    spi_cs_n [*6] |-> ($past(diag_flags) & ~diag_flags) == '0)
    else $error("flag cleared without frame");
endmodule : occ_ctrl_checker
bind occ_ctrl occ_ctrl_checker i_chk (.clk(clk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
  .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
  .channel_input_pin(channel_input_pin), .channel_fault(channel_fault),
  .channel_drive(channel_drive), .diag_flags(diag_flags));
`default_nettype wire

// File: verification/occ_host_model.sv
// Host side model: serial master that sends frames to the block
`timescale 1ns/1ps
`default_nettype none
module occ_host_model
  import occ_pkg::*;
(
  input wire logic clk, // System clock
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock, idle low
  output logic si, // Serial data to device
  input wire logic so // Serial data from device
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // ********
  // Frame transfer, full duplex, MSB first
  // ********
  // Fewer than 16 bits is allowed so that refusal can be exercised
  task automatic xfer(input occ_frame_t f, input int nbits,
                      output logic [FRAME_W-1:0] rsp);
    rsp = '0;
    @(negedge clk) cs_n = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = FRAME_W - 1; i >= FRAME_W - nbits; i--) begin
      si = f[i];
      repeat (2) @(negedge clk);
      rsp[i] = so;
      sclk = 1'b1;
      repeat (2) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    // Released data line must not look like a valid bit
    si = ~si;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : occ_host_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the output channel control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import occ_pkg::*;
;
  logic clk;
  logic rst;
  logic cs_n, sclk, si, so;
  logic [NUM_CH-1:0] pins, fault, drv, diag;
  logic [FRAME_W-1:0] rsp;
  int error_cnt = 0;
  int total_checks = 0;
  logic [REG_W-1:0] rst_tab [4] = '{12'hc00, 12'haaa, 12'h0aa, 12'h000};
  logic [REG_W-1:0] pon [3] = '{12'h041, 12'h010, 12'h008};
  logic [NUM_CH-1:0] pdrv [3] = '{10'h3cf, 10'h030, 10'h000};
  // ********
  // Clock, design and host
  // ********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  occ_ctrl i_dut (.clk(clk), .rst(rst), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_si(si), .spi_so(so), .spi_so_oe_n(),
    .channel_input_pin(pins), .channel_fault(fault),
    .channel_drive(drv), .diag_flags(diag));
  occ_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so));
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [3:0] cmd, input logic [REG_W-1:0] d);
    i_host.xfer(occ_frame_t'{cmd, d}, FRAME_W, rsp);
  endtask : send
  // Read data comes back in the frame after the read
  task automatic rd_chk(input logic [1:0] sel, input logic [REG_W-1:0] e);
    send(CMD_RD, {10'h000, sel});
    send(CMD_RD, {10'h000, sel});
    chk(rsp, {4'h0, e});
  endtask : rd_chk
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    rst = 1'b1;
    pins = '0;
    fault = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    pins = 10'h2a5;
    repeat (3) @(negedge clk);
    chk({6'h0, drv}, 16'h02a5);
    for (int i = 0; i < 4; i++) begin
      rd_chk(2'(i), rst_tab[i]);
    end
    send(CMD_WR_PAIR, 12'hfff);
    rd_chk(RD_PAIR, 12'h0f7);
    send(CMD_WR_SEL_LO, 12'h000);
    send(CMD_WR_SEL_HI, 12'h000);
    for (int i = 0; i < 3; i++) begin
      send(CMD_WR_ON, pon[i]);
      chk({6'h0, drv}, {6'h0, pdrv[i]});
    end
    send(CMD_WR_PAIR, 12'h000);
    chk({6'h0, drv}, 16'h0008);
    send(CMD_WR_ON, 12'h155);
    rd_chk(RD_ON, 12'hd55);
    chk({6'h0, drv}, 16'h0155);
    pins = 10'h0f0;
    send(CMD_WR_SEL_HI, 12'hfff);
    rd_chk(RD_SEL_HI, 12'h0ff);
    send(CMD_WR_SEL_LO, 12'hfff);
    chk({6'h0, drv}, 16'h0050);
    send(CMD_WR_SEL_LO, 12'h555);
    send(CMD_WR_SEL_HI, 12'h055);
    chk({6'h0, drv}, 16'h0155);
    i_host.xfer(occ_frame_t'{CMD_WR_ON, 12'h000}, 15, rsp);
    chk({6'h0, drv}, 16'h0155);
    send(CMD_PIN_SET, 12'h0a5);
    pins = 10'h140;
    send(CMD_PIN_SET, 12'h0a5);
    chk(rsp, 16'hf500);
    pins = 10'h000;
    send(CMD_PIN_SET, 12'h0a5);
    chk(rsp, 16'ha500);
    // Pair channels 1 and 2, then fault only channel 2
    send(CMD_WR_PAIR, 12'h001);
    chk({6'h0, drv}, 16'h0157);
    fault = 10'h002;
    repeat (2) @(negedge clk);
    fault = '0;
    repeat (2) @(negedge clk);
    chk({6'h0, diag}, 16'h0002);
    chk({15'h0, diag[0] | diag[1]}, 16'h0001);
    send(CMD_DIAG_CLR, 12'hfff);
    chk({6'h0, diag}, 16'h0000);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
